// ### hw/adc_readout_params.svh
// Offsets, field positions, reset values and counts for the parallel readout block
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH
`define ADDR_STATUS 8'h00
`define ADDR_MASK 8'h04
`define ADDR_PINS 8'h08
`define ADDR_WORD 8'h0C
`define ADDR_CTRL 8'h10
`define ST_BIT_UPD 0
`define ST_BIT_OVR 1
`define ST_BIT_VALID 2
`define CTRL_BIT_SYNC 0
`define MASK_RST 3'h0
`define STATUS_RST 3'h0
`define WORD_PERIOD 32
`define SETTLE_WORDS 4
`define GAP_CYCLES 2
`define LOW_PWR_MAX_MHZ 10
`endif

// ### hw/adc_readout_pkg.sv
// Types shared by the parallel readout block
package adc_readout_pkg;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic sync_in;
    logic power_down_in;
    logic low_power_select;
    logic iface_select_b;
    logic iface_select_a;
    logic osc_disable;
    logic range_select;
  } pin_bus_t;
  typedef struct packed {
    logic parallel;
    logic bandpass;
  } mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [1:0] {ST_RUN, ST_SYNC, ST_SETTLE, ST_POWER_DOWN_IN} seq_state_t;
endpackage

// ### hw/adc_parallel_readout_control.sv
// Pin control, filter sequencer and parallel readout of the converter
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
`include "adc_readout_params.svh"

// Function
// - Range select high means unipolar input, low means bipolar input.
// - Oscillator disable high turns crystal amplifier off, external clock used.
// - Two mode selects choose parallel or serial and the parallel filter mode.
// - Sync rising edge zeroes the sequencer counter and holds the filter reset.
// - Sync reset ends at the first clock edge that samples sync low.
// - Devices on one clock and sync pulse sample and update together.
// - Standby high keeps the device powered down.
// - Output drivers turn on when a clock edge sees read and select low.
// - Read sampled high puts all sixteen output bits in high impedance.
// - Word ready falls when a new word sits in the output register.
// - Word ready returns high once a read has completed.
// - Unread word: word ready goes high two cycles before next update.
// - After sync, word ready falls only when valid results exist again.
// - Word MSB drives the highest numbered output bit.
module adc_parallel_readout_control #(
  parameter int WORD_PERIOD = `WORD_PERIOD,
  parameter int SETTLE_WORDS = `SETTLE_WORDS,
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire adc_readout_pkg::pin_bus_t pins,
  input wire logic [DATA_W-1:0] conv_word,
  input wire adc_readout_pkg::reg_req_t req,
  output logic [31:0] rdata,
  output logic [DATA_W-1:0] out_bits,
  output logic out_bits_oe,
  output logic word_ready_n,
  output logic filter_reset,
  output logic unipolar,
  output logic xtal_amp_en,
  output adc_readout_pkg::mode_t mode,
  output logic half_power,
  output logic standby,
  output logic irq
);
  import adc_readout_pkg::*;

  localparam int CW = $clog2(WORD_PERIOD);
  localparam int SW = $clog2(SETTLE_WORDS + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(WORD_PERIOD - 1);
  localparam logic [CW-1:0] CNT_GAP = CW'(WORD_PERIOD - 1 - `GAP_CYCLES);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_WORDS - 1);

  function automatic mode_t mode_decode(input logic sel_a, input logic sel_b);
    mode_t m;
    m.parallel = ~sel_a;
    m.bandpass = sel_b;
    return m;
  endfunction

  // Two-flop synchronisers for every pin
  pin_bus_t pins_meta_r;
  pin_bus_t pins_s_r;
  logic sync_d_r;
  genvar gi;
  generate
    for (gi = 0; gi < $bits(pin_bus_t); gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          pins_meta_r[gi] <= 1'b1;
          pins_s_r[gi] <= 1'b1;
        end else begin
          pins_meta_r[gi] <= pins[gi];
          pins_s_r[gi] <= pins_meta_r[gi];
        end
      end
    end
  endgenerate

  seq_state_t state_r, state_nxt;
  logic [CW-1:0] seq_cnt_r, seq_cnt_nxt;
  logic [SW-1:0] settle_r, settle_nxt;
  logic [DATA_W-1:0] word_r;
  logic oe_r;
  logic word_ready_n_r, word_ready_n_nxt;
  logic frst_r;
  logic soft_sync_r;
  logic unread_r;
  logic [2:0] status_r, status_nxt, mask_r;
  logic irq_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic uni_r, xamp_r, half_r, power_down_in_r;
  mode_t mode_r;

  wire pdown = pins_s_r.power_down_in;
  wire sync_s = pins_s_r.sync_in;
  wire sync_rise = (sync_s & ~sync_d_r) | soft_sync_r;
  wire rd_low_sel = ~pins_s_r.rd_n & ~pins_s_r.cs_n;
  wire read_done = oe_r & ~rd_low_sel;
  wire tick = (seq_cnt_r == CNT_LAST) && (state_r == ST_RUN || state_r == ST_SETTLE);
  wire settle_end = (state_r == ST_SETTLE) && (settle_r == SETTLE_LAST);
  wire update = tick && (state_r == ST_RUN || settle_end);
  wire pre_upd = (state_r == ST_RUN) && (seq_cnt_r >= CNT_GAP) && !update;
  wire overrun = update & unread_r & (state_r == ST_RUN);
  wire mode_t mode_w = mode_decode(pins_s_r.iface_select_a, pins_s_r.iface_select_b);
  wire hit_status = req.rd && (req.addr == `ADDR_STATUS);
  wire [2:0] events = {settle_end & tick, overrun, update};

  // Sequencer state machine
  always_comb begin
    state_nxt = state_r;
    seq_cnt_nxt = seq_cnt_r + CW'(1);
    settle_nxt = settle_r;
    case (state_r)
      ST_RUN: begin
        if (tick) begin
          seq_cnt_nxt = '0;
        end
      end
      ST_SYNC: begin
        seq_cnt_nxt = '0;
        settle_nxt = '0;
        if (!sync_s) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tick) begin
          seq_cnt_nxt = '0;
          settle_nxt = settle_r + SW'(1);
          if (settle_end) begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_POWER_DOWN_IN: begin
        seq_cnt_nxt = '0;
        settle_nxt = '0;
        if (!pdown) begin
          state_nxt = ST_SETTLE;
        end
      end
      default: begin
        state_nxt = ST_SYNC;
      end
    endcase
    if (pdown) begin
      state_nxt = ST_POWER_DOWN_IN;
      seq_cnt_nxt = '0;
    end else if (sync_rise) begin
      state_nxt = ST_SYNC;
      seq_cnt_nxt = '0;
    end
  end

  // Word ready: low on update, high on read, gap, or no valid results
  always_comb begin
    if (update) begin
      word_ready_n_nxt = 1'b0;
    end else if (state_r != ST_RUN || read_done) begin
      word_ready_n_nxt = 1'b1;
    end else if (pre_upd) begin
      word_ready_n_nxt = 1'b1;
    end else begin
      word_ready_n_nxt = word_ready_n_r;
    end
  end

  assign status_nxt = (status_r & ~{3{hit_status}}) | events;

  always_comb begin
    case (req.addr)
      `ADDR_STATUS: rdata_nxt = {29'h0, status_r};
      `ADDR_MASK: rdata_nxt = {29'h0, mask_r};
      `ADDR_PINS: rdata_nxt = {19'h0, state_r, frst_r, word_ready_n_r, pins_s_r};
      `ADDR_WORD: rdata_nxt = {{(32 - DATA_W){1'b0}}, word_r};
      default: rdata_nxt = 32'h0;
    endcase
    if (!req.rd) begin
      rdata_nxt = 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= ST_SYNC;
      seq_cnt_r <= '0;
      settle_r <= '0;
      sync_d_r <= 1'b1;
      word_ready_n_r <= 1'b1;
      frst_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      seq_cnt_r <= seq_cnt_nxt;
      settle_r <= settle_nxt;
      sync_d_r <= sync_s;
      word_ready_n_r <= word_ready_n_nxt;
      frst_r <= (state_nxt == ST_SYNC) || (state_nxt == ST_POWER_DOWN_IN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      word_r <= '0;
      oe_r <= 1'b0;
    end else begin
      if (update) begin
        word_r <= conv_word;
      end
      oe_r <= rd_low_sel;
    end
  end

  // Word left unread across an update in the run state counts as an overrun
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      unread_r <= 1'b0;
    end else if (update) begin
      unread_r <= 1'b1;
    end else if (read_done) begin
      unread_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      uni_r <= 1'b0;
      xamp_r <= 1'b1;
      mode_r <= '0;
      half_r <= 1'b0;
      power_down_in_r <= 1'b0;
    end else begin
      uni_r <= pins_s_r.range_select;
      xamp_r <= ~pins_s_r.osc_disable;
      mode_r <= mode_w;
      half_r <= pins_s_r.low_power_select;
      power_down_in_r <= pdown;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_r <= `STATUS_RST;
      mask_r <= `MASK_RST;
      irq_r <= 1'b0;
      rdata_r <= 32'h0;
      soft_sync_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (req.wr && req.addr == `ADDR_MASK) begin
        mask_r <= req.wdata[2:0];
      end
      irq_r <= |(status_nxt & mask_r);
      rdata_r <= rdata_nxt;
      soft_sync_r <= req.wr && (req.addr == `ADDR_CTRL) && req.wdata[`CTRL_BIT_SYNC];
    end
  end

  assign rdata = rdata_r;
  assign out_bits = word_r;
  assign out_bits_oe = oe_r;
  assign word_ready_n = word_ready_n_r;
  assign filter_reset = frst_r;
  assign unipolar = uni_r;
  assign xtal_amp_en = xamp_r;
  assign mode = mode_r;
  assign half_power = half_r;
  assign standby = power_down_in_r;
  assign irq = irq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_gap;
    word_ready_n [*2];
  endsequence
  sequence s_power_down_in_hold;
    pdown [*2];
  endsequence

  AST_OE_ON: assert property (rd_low_sel |=> out_bits_oe) else $error("drivers not enabled");
  AST_OE_SEL: assert property (pins_s_r.cs_n |=> !out_bits_oe) else $error("drove while deselected");
  AST_OE_OFF: assert property (pins_s_r.rd_n |=> !out_bits_oe) else $error("drivers not released");
  AST_SYNC_RST: assert property ((sync_rise && !pdown) |=> filter_reset && seq_cnt_r == '0)
    else $error("sync did not reset sequencer");
  AST_SYNC_REL: assert property ((state_r == ST_SYNC && !sync_s && !pdown && !sync_rise)
    |=> !filter_reset) else $error("sync reset not released");
  AST_UPD: assert property (update |=> !word_ready_n && out_bits == $past(conv_word))
    else $error("update did not present word");
  AST_READ_DONE: assert property ((read_done && !update) |=> word_ready_n)
    else $error("ready not raised after read");
  AST_RDY_UNREAD: assert property (!word_ready_n |-> unread_r)
    else $error("ready low with no unread word");
  AST_GAP: assert property ((state_r == ST_RUN && seq_cnt_r == CNT_GAP && !update) |=> s_gap)
    else $error("gap before update missing");
  AST_OVR: assert property (overrun |=> status_r[`ST_BIT_OVR])
    else $error("overrun not flagged");
  AST_POWER_DOWN_IN: assert property (s_power_down_in_hold |=> word_ready_n && state_r == ST_POWER_DOWN_IN && standby)
    else $error("standby not held");
  AST_SETTLE: assert property (state_r == ST_SYNC |=> word_ready_n ##1 word_ready_n)
    else $error("ready during sync");
  AST_VALID: assert property ((settle_end && tick) |=> status_r[`ST_BIT_VALID] && !word_ready_n)
    else $error("valid results not flagged");
  AST_HOLD: assert property (!update |=> $stable(out_bits)) else $error("word changed between updates");
endmodule // adc_parallel_readout_control

// ### tb/host_reader_model.sv
// Host that reads one word at a time over the parallel bus
`timescale 1ns/100ps
module host_reader_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic sel_off,
  input wire logic [15:0] out_bits,
  input wire logic out_bits_oe,
  output logic cs_n,
  output logic rd_n,
  output logic [15:0] word,
  output logic got,
  output logic done
);
  logic [15:0] last_r = 16'h0000;
  // Released bus shows the inverse of its last level
  wire [15:0] bus_lvl = out_bits_oe ? out_bits : ~last_r;
  always @(posedge core_clk) last_r <= bus_lvl;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    word = 16'h0000;
    got = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge core_clk);
      done <= 1'b0;
      if (go) begin
        cs_n <= sel_off;
        rd_n <= 1'b0;
        for (int i = 0; i < 8 && out_bits_oe !== 1'b1; i++) @(posedge core_clk);
        got <= out_bits_oe;
        word <= bus_lvl;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        for (int i = 0; i < 8 && out_bits_oe !== 1'b0; i++) @(posedge core_clk);
        done <= 1'b1;
      end
    end
  end
endmodule // host_reader_model

// ### tb/testbench.sv
// Self-checking bench for the parallel readout block
`timescale 1ns/100ps
`include "adc_readout_params.svh"
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
  import adc_readout_pkg::*;
  localparam int P = 32;
  localparam int S = 4;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] strap = 7'h00;
  logic [15:0] conv_word = 16'hA5C3;
  reg_req_t req = '0;
  logic go = 1'b0;
  logic sel_off = 1'b0;
  logic h_cs_n, h_rd_n, h_got, h_done;
  logic [15:0] h_word;
  pin_bus_t pins_w;
  logic [31:0] rdata;
  logic [15:0] out_bits;
  logic out_bits_oe, word_ready_n, filter_reset, unipolar, xtal_amp_en, half_power, standby, irq;
  mode_t mode;
  int bad_count = 0;
  int checks_done = 0;
  logic [31:0] rv;
  int n;
  assign pins_w = pin_bus_t'({h_cs_n, h_rd_n, strap});
  always #2.5 core_clk = ~core_clk;
  adc_parallel_readout_control #(.WORD_PERIOD(P), .SETTLE_WORDS(S), .DATA_W(16)) dut (
    .core_clk(core_clk), .nrst(nrst), .pins(pins_w), .conv_word(conv_word), .req(req), .rdata(rdata),
    .out_bits(out_bits), .out_bits_oe(out_bits_oe), .word_ready_n(word_ready_n),
    .filter_reset(filter_reset), .unipolar(unipolar), .xtal_amp_en(xtal_amp_en), .mode(mode),
    .half_power(half_power), .standby(standby), .irq(irq));
  host_reader_model host (.core_clk(core_clk), .go(go), .sel_off(sel_off), .out_bits(out_bits),
    .out_bits_oe(out_bits_oe), .cs_n(h_cs_n), .rd_n(h_rd_n), .word(h_word), .got(h_got), .done(h_done));
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic rr(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic wait_rdy(input logic lvl, input int lim, output int k);
    k = 0;
    while (word_ready_n !== lvl && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic rd_host(input logic off);
    @(posedge core_clk);
    go <= 1'b1;
    sel_off <= off;
    @(posedge core_clk);
    go <= 1'b0;
    for (int i = 0; i < 40 && h_done !== 1'b1; i++) cyc(1);
  endtask
  task automatic t_straps;
    logic [3:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 4'(16'h0FA5 >> (4 * k));
      @(posedge core_clk);
      strap[4:0] <= {1'b0, v}; // Low power pin stays low at this clock rate
      cyc(4);
      `CHK(unipolar, v[0], "range")
      `CHK(xtal_amp_en, ~v[1], "osc")
      `CHK(mode, {~v[2], v[3]}, "mode")
      `CHK(half_power, 1'b0, "low power")
    end
    rr(`ADDR_PINS, rv);
    `CHK(rv[8:0], {2'b11, strap}, "pin view")
    $display("straps done");
  endtask
  task automatic t_read;
    wait_rdy(1'b0, S * P + 64, n);
    `CHK(word_ready_n, 1'b0, "no first word")
    rd_host(1'b0);
    `CHK(h_got, 1'b1, "no drive")
    `CHK(h_word, 16'hA5C3, "bus word")
    `CHK(out_bits_oe, 1'b0, "still driven")
    `CHK(word_ready_n, 1'b1, "ready stuck")
    $display("read done");
  endtask
  task automatic t_unread;
    @(posedge core_clk);
    conv_word <= 16'h3C5A;
    wait_rdy(1'b0, P + 8, n);
    @(posedge core_clk);
    conv_word <= 16'h1234;
    rr(`ADDR_WORD, rv);
    `CHK(rv, 32'h00003C5A, "word reg")
    wait_rdy(1'b1, P + 8, n);
    `CHK(out_bits, 16'h3C5A, "word moved")
    wait_rdy(1'b0, 8, n);
    `CHK(n, 2, "high width")
    `CHK(out_bits, 16'h1234, "no update")
    $display("unread done");
  endtask
  task automatic t_irq;
    rr(`ADDR_STATUS, rv);
    rw(`ADDR_MASK, 32'h1);
    rr(`ADDR_MASK, rv);
    `CHK(rv, 32'h1, "mask")
    wait_rdy(1'b1, P + 8, n);
    wait_rdy(1'b0, 8, n);
    cyc(2);
    `CHK(irq, 1'b1, "irq")
    rw(`ADDR_MASK, 32'h0);
    cyc(2);
    `CHK(irq, 1'b0, "masked")
    rw(`ADDR_MASK, 32'h1);
    rr(`ADDR_STATUS, rv);
    `CHK(rv[0], 1'b1, "status")
    `CHK(rv[1], 1'b1, "overrun")
    cyc(2);
    `CHK(irq, 1'b0, "not cleared")
    rr(8'hFC, rv);
    `CHK(rv, 32'h0, "unmapped")
    rd_host(1'b1);
    `CHK(h_got, 1'b0, "drove unselected")
    $display("irq done");
  endtask
  task automatic t_sync;
    @(posedge core_clk);
    strap[5] <= 1'b1;
    cyc(4);
    `CHK(standby, 1'b1, "standby")
    `CHK(filter_reset, 1'b1, "awake")
    wait_rdy(1'b0, P + 8, n);
    `CHK(word_ready_n, 1'b1, "word in standby")
    @(posedge core_clk);
    strap[5] <= 1'b0;
    wait_rdy(1'b0, S * P + 64, n);
    `CHK(word_ready_n, 1'b0, "no word after standby")
    rr(`ADDR_STATUS, rv);
    `CHK(rv[2], 1'b1, "no valid after standby")
    @(posedge core_clk);
    strap[6] <= 1'b1; // Single pulse
    cyc(10);
    `CHK(filter_reset, 1'b1, "left early")
    `CHK(word_ready_n, 1'b1, "ready in sync")
    @(posedge core_clk);
    strap[6] <= 1'b0;
    cyc(4);
    `CHK(filter_reset, 1'b0, "held")
    wait_rdy(1'b0, S * P + 64, n);
    `CHK(n >= (S - 1) * P, 1'b1, "early word")
    rr(`ADDR_STATUS, rv);
    `CHK(rv[2], 1'b1, "no valid")
    rw(`ADDR_CTRL, 32'h1);
    wait_rdy(1'b1, 8, n);
    wait_rdy(1'b0, S * P + 64, n);
    `CHK(n >= (S - 1) * P && n < S * P + 64, 1'b1, "soft sync")
    $display("sync done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    cyc(2);
    t_straps;
    t_read;
    t_unread;
    t_irq;
    t_sync;
    close_out;
  end
  // Tests need about 750 cycles
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule // testbench
